/* File: common/lcrc_pkg.sv */
// What this block does
// - a start press longer than 5 s is not taken as a start request.
// - a qualified start acts on the release of the button.
// - in lockout a press of 10 s to 20 s inclusive clears lockout, and starts only if the field is clear.
// - in the reduced five-pin variant there is no manual start.
// - in the reduced five-pin variant contactor feedback is ignored.
// - auto reset re-enables outputs within 210 ms if both sync beams blocked.
// - auto reset re-enables outputs within 33 ms if zero or one was blocked.
// - exactly two sync beams, lowest and highest, decide the restart delay.
// - with four-sensor muting the receiver takes four sensors, drives a lamp.
package lcrc_pkg;
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned T_PRESS_MIN_MS = 50;
   localparam int unsigned T_PRESS_MAX_MS = 5_000;
   localparam int unsigned T_LOCK_MIN_MS  = 10_000;
   localparam int unsigned T_LOCK_MAX_MS  = 20_000;
   localparam int unsigned T_RST_BOTH_MS  = 210;
   localparam int unsigned T_RST_ONE_MS   = 33;
   localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
   localparam int unsigned CNT_W          = 32;
   // least times round up, longest round down (integral ms here)
   localparam int unsigned PRESS_MIN_CYC = T_PRESS_MIN_MS * CYC_PER_MS;
   localparam int unsigned PRESS_MAX_CYC = T_PRESS_MAX_MS * CYC_PER_MS;
   localparam int unsigned LOCK_MIN_CYC  = T_LOCK_MIN_MS * CYC_PER_MS;
   localparam int unsigned LOCK_MAX_CYC  = T_LOCK_MAX_MS * CYC_PER_MS;
   // restart delays kept just below the limits; the machine spends two
   // edges beyond the delay count (enter wait, register outputs)
   localparam int unsigned RST_BOTH_CYC  = T_RST_BOTH_MS * CYC_PER_MS - 3;
   localparam int unsigned RST_ONE_CYC   = T_RST_ONE_MS * CYC_PER_MS - 3;
   localparam int unsigned NUM_SYNC      = 2;
   localparam int unsigned NUM_MUTE      = 4;

   typedef enum logic [1:0] {
      LCRC_OFF     = 2'b00,
      LCRC_WAIT    = 2'b01,
      LCRC_ON      = 2'b10,
      LCRC_LOCKOUT = 2'b11
   } lcrc_state_t;
endpackage

/* File: hw/lcrc_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module lcrc_ctrl #(
   parameter int unsigned PRESS_MIN = lcrc_pkg::PRESS_MIN_CYC,
   parameter int unsigned PRESS_MAX = lcrc_pkg::PRESS_MAX_CYC,
   parameter int unsigned LOCK_MIN  = lcrc_pkg::LOCK_MIN_CYC,
   parameter int unsigned LOCK_MAX  = lcrc_pkg::LOCK_MAX_CYC,
   parameter int unsigned RST_BOTH  = lcrc_pkg::RST_BOTH_CYC,
   parameter int unsigned RST_ONE   = lcrc_pkg::RST_ONE_CYC
) (
   // clock and control
   input  wire logic                          mclk_i,
   input  wire logic                          srst_i,
   input  wire logic                          ce_i,
   // configuration straps
   input  wire logic                          five_pin_i,
   input  wire logic                          auto_reset_i,
   input  wire logic                          mute_four_i,
   // field and beams
   input  wire logic                          field_clear_i,
   input  wire logic [lcrc_pkg::NUM_SYNC-1:0] sync_blocked_i,
   input  wire logic                          fault_i,
   // operator and external devices
   input  wire logic                          start_button_i,
   input  wire logic                          contactor_feedback_monitor_i,
   input  wire logic [lcrc_pkg::NUM_MUTE-1:0] muting_sensor_i,
   // outputs
   output logic                               safety_out_a_o,
   output logic                               safety_out_b_o,
   output logic                               lockout_o,
   output logic                               muting_lamp_o,
   output logic [lcrc_pkg::NUM_MUTE-1:0]      muting_active_o
);
   import lcrc_pkg::*;

   // ****************************************
   // press timing
   // ****************************************
   logic             released;
   logic [CNT_W-1:0] held;
   wire  logic       button = start_button_i & ~five_pin_i;

   lcrc_press_timer #(.CNT_W(CNT_W)) u_press (
      .mclk_i    (mclk_i),
      .srst_i    (srst_i),
      .ce_i      (ce_i),
      .press_i   (button),
      .release_o (released),
      .held_o    (held)
   );

   wire logic start_ok = released & (held >= CNT_W'(PRESS_MIN))
                       & (held <= CNT_W'(PRESS_MAX));
   wire logic lock_ok  = released & (held >= CNT_W'(LOCK_MIN))
                       & (held <= CNT_W'(LOCK_MAX));

   // ****************************************
   // restart state
   // ****************************************
   lcrc_state_t      state;
   lcrc_state_t      next_state;
   logic             both_seen;
   logic [CNT_W-1:0] dly;
   wire  logic both_blk = &sync_blocked_i;
   wire  logic edm_ok   = five_pin_i
                        | contactor_feedback_monitor_i;
   wire  logic [CNT_W-1:0] dly_lim = both_seen ? CNT_W'(RST_BOTH)
                                               : CNT_W'(RST_ONE);
   wire  logic dly_done = dly >= dly_lim;

   always_comb begin
      next_state = state;
      case (state)
         LCRC_OFF: begin
            if (fault_i)
               next_state = LCRC_LOCKOUT;
            else if (field_clear_i && auto_reset_i && !five_pin_i)
               next_state = LCRC_WAIT;
            else if (field_clear_i && auto_reset_i && five_pin_i)
               next_state = LCRC_WAIT;
            else if (field_clear_i && start_ok && edm_ok)
               next_state = LCRC_ON;
         end
         LCRC_WAIT: begin
            if (fault_i)
               next_state = LCRC_LOCKOUT;
            else if (!field_clear_i)
               next_state = LCRC_OFF;
            else if (dly_done && edm_ok)
               next_state = LCRC_ON;
         end
         LCRC_ON: begin
            if (fault_i)
               next_state = LCRC_LOCKOUT;
            else if (!field_clear_i)
               next_state = LCRC_OFF;
         end
         LCRC_LOCKOUT: begin
            if (lock_ok && !fault_i)
               next_state = field_clear_i ? LCRC_ON : LCRC_OFF;
         end
         default: next_state = LCRC_OFF;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state     <= LCRC_OFF;
         both_seen <= 1'b0;
         dly       <= '0;
      end else if (ce_i) begin
         state <= next_state;
         if (state == LCRC_WAIT)
            dly <= dly + 1'b1;
         else
            dly <= '0;
         if (state == LCRC_ON)
            both_seen <= 1'b0;
         else if (!field_clear_i && both_blk)
            both_seen <= 1'b1;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         safety_out_a_o  <= 1'b0;
         safety_out_b_o  <= 1'b0;
         lockout_o       <= 1'b0;
         muting_lamp_o   <= 1'b0;
         muting_active_o <= '0;
      end else if (ce_i) begin
         safety_out_a_o  <= (next_state == LCRC_ON);
         safety_out_b_o  <= (next_state == LCRC_ON);
         lockout_o       <= (next_state == LCRC_LOCKOUT);
         muting_active_o <= mute_four_i ? muting_sensor_i
                                        : '0;
         muting_lamp_o   <= mute_four_i & (|muting_sensor_i);
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_lock_holds_off: assert property (@(posedge mclk_i) disable iff (srst_i)
      lockout_o |-> !safety_out_a_o && !safety_out_b_o)
      else $error("output on during lockout");
   a_outs_equal: assert property (@(posedge mclk_i) disable iff (srst_i)
      safety_out_a_o == safety_out_b_o)
      else $error("safety outputs differ");
   a_five_no_start: assert property (@(posedge mclk_i) disable iff (srst_i)
      five_pin_i |-> !released)
      else $error("start handled in five-pin variant");
   a_start_min: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && state == LCRC_OFF && !auto_reset_i && field_clear_i && !fault_i
      && released && held < CNT_W'(PRESS_MIN) |=> !safety_out_a_o)
      else $error("short press started outputs");
   a_start_max: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && state == LCRC_OFF && !auto_reset_i && released
      && held > CNT_W'(PRESS_MAX) |=> !safety_out_a_o)
      else $error("overlong press started outputs");
   a_start_fall: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && state == LCRC_OFF && !auto_reset_i && button
      |=> !safety_out_a_o)
      else $error("start acted before release");
   a_lock_release: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && state == LCRC_LOCKOUT && lock_ok && !fault_i |=> !lockout_o)
      else $error("lockout not cleared");
   a_restart_both: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && state == LCRC_WAIT && both_seen && dly < dly_lim
      |=> !safety_out_a_o)
      else $error("restart delay too short");
   a_restart_one: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && state == LCRC_WAIT && dly_done && edm_ok && field_clear_i
      && !fault_i |=> safety_out_a_o)
      else $error("restart not taken at limit");
   a_edm_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && state == LCRC_WAIT && !edm_ok |=> !safety_out_a_o)
      else $error("started without feedback");
   a_mute_off: assert property (@(posedge mclk_i) disable iff (srst_i)
      !mute_four_i && ce_i |=> muting_active_o == '0)
      else $error("muting active while unconfigured");
   a_fault_lock: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && fault_i |=> lockout_o && !safety_out_a_o)
      else $error("fault did not lock out");
   a_field_cut: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && !field_clear_i |=> !safety_out_a_o)
      else $error("output on while field interrupted");
   a_lamp_map: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && mute_four_i |=> muting_lamp_o == |$past(muting_sensor_i))
      else $error("muting lamp wrong");
   a_lock_short: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && state == LCRC_LOCKOUT && !lock_ok |=> lockout_o)
      else $error("lockout left without long press");
   a_seen_both: assert property (@(posedge mclk_i) disable iff (srst_i)
      ce_i && !field_clear_i && both_blk && state != LCRC_ON
      |=> both_seen)
      else $error("both sync beams not noted");
   a_ce_freeze: assert property (@(posedge mclk_i) disable iff (srst_i)
      !ce_i |=> $stable(safety_out_a_o) && $stable(lockout_o))
      else $error("state moved while enable low");

   c_manual: cover property (@(posedge mclk_i) disable iff (srst_i)
      state == LCRC_OFF && start_ok && field_clear_i ##1 safety_out_a_o);
   c_auto: cover property (@(posedge mclk_i) disable iff (srst_i)
      state == LCRC_WAIT ##1 state == LCRC_ON);
   c_unlock: cover property (@(posedge mclk_i) disable iff (srst_i)
      state == LCRC_LOCKOUT && lock_ok);
   c_lock_enter: cover property (@(posedge mclk_i) disable iff (srst_i)
      state != LCRC_LOCKOUT ##1 state == LCRC_LOCKOUT);
endmodule
`default_nettype wire

/* File: hw/lcrc_press_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module lcrc_press_timer #(
   parameter int unsigned CNT_W = 32
) (
   // clock and control
   input  wire logic             mclk_i,
   input  wire logic             srst_i,
   input  wire logic             ce_i,
   // button level
   input  wire logic             press_i,
   // results
   output logic                  release_o,
   output logic [CNT_W-1:0]      held_o
);
   logic             press_d;
   logic [CNT_W-1:0] cnt;
   wire  logic       sat = &cnt;

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         press_d <= 1'b0;
         cnt     <= '0;
      end else if (ce_i) begin
         press_d <= press_i;
         if (!press_i)
            cnt <= '0;
         else if (!sat)
            cnt <= cnt + 1'b1;
      end
   end

   // falling edge of the press, with length held before it
   assign release_o = ce_i & press_d & ~press_i;
   assign held_o    = cnt;
endmodule
`default_nettype wire

/* File: tb/lcrc_relay_model.sv */
`timescale 1ns/1ns
`default_nettype none
module lcrc_relay_model (
   // clock
   input  wire logic mclk_i,
   // safety outputs of the block
   input  wire logic safety_out_a_i,
   input  wire logic safety_out_b_i,
   input  wire logic fb_stuck_i,
   // towards the block
   output logic      start_button_o,
   output logic      contactor_feedback_monitor_o,
   output logic      machine_safe_o
);
   // ***********
   // relay side
   // ***********
   logic k1;
   logic k2;
   initial start_button_o = 1'b0;
   // one contactor for each channel, never merged
   always @(posedge mclk_i) begin
      k1 <= safety_out_a_i;
      k2 <= safety_out_b_i;
   end
   assign machine_safe_o = !(safety_out_a_i && safety_out_b_i);
   // high only while both contactors are released
   assign contactor_feedback_monitor_o = !(k1 || k2) && !fb_stuck_i;
   // operator press, n cycles sampled high
   task automatic press(input int n);
      @(negedge mclk_i);
      start_button_o = 1'b1;
      repeat (n) @(negedge mclk_i);
      start_button_o = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb/test_light_curtain_restart_output_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module test_light_curtain_restart_output_ctrl;
   import lcrc_pkg::*;
   // ***********
   // bench
   // ***********
   localparam int P_MIN = 5;
   localparam int P_MAX = 50;
   localparam int L_MIN = 100;
   localparam int L_MAX = 200;
   localparam int R_BOTH = 20;
   localparam int R_ONE = 8;
   logic       mclk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic       five_pin_i = 1'b0;
   logic       auto_reset_i = 1'b0;
   logic       mute_four_i = 1'b0;
   logic       field_clear_i = 1'b1;
   logic [1:0] sync_blocked_i = 2'h0;
   logic       fault_i = 1'b0;
   logic [3:0] muting_sensor_i = 4'h0;
   logic       fb_stuck = 1'b0;
   logic       out_a, out_b, lock, lamp, start, fb;
   logic [3:0] active;
   wire  logic [3:0] st;
   int         err_total = 0;
   int         checks = 0;
   int         cyc = 0;
   assign st = {1'b0, lock, out_b, out_a};
   initial forever #10 mclk_i = ~mclk_i;
   lcrc_ctrl #(.PRESS_MIN(P_MIN), .PRESS_MAX(P_MAX), .LOCK_MIN(L_MIN),
      .LOCK_MAX(L_MAX), .RST_BOTH(R_BOTH), .RST_ONE(R_ONE)) u_lcrc_ctrl (
      .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(1'b1),
      .five_pin_i(five_pin_i), .auto_reset_i(auto_reset_i),
      .mute_four_i(mute_four_i), .field_clear_i(field_clear_i),
      .sync_blocked_i(sync_blocked_i), .fault_i(fault_i),
      .start_button_i(start), .contactor_feedback_monitor_i(fb),
      .muting_sensor_i(muting_sensor_i), .safety_out_a_o(out_a),
      .safety_out_b_o(out_b), .lockout_o(lock), .muting_lamp_o(lamp),
      .muting_active_o(active));
   lcrc_relay_model u_lcrc_relay_model (.mclk_i(mclk_i),
      .safety_out_a_i(out_a), .safety_out_b_i(out_b), .fb_stuck_i(fb_stuck),
      .start_button_o(start), .contactor_feedback_monitor_o(fb),
      .machine_safe_o());
   task automatic summarize;
      if (err_total == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   // interrupt the field with the given sync beams blocked
   task automatic cut(input logic [1:0] sb);
      @(negedge mclk_i);
      field_clear_i = 1'b0;
      sync_blocked_i = sb;
      step(3);
      field_clear_i = 1'b1;
      sync_blocked_i = 2'h0;
   endtask
   task automatic t_manual;
      cut(2'h0);
      step(3);
      u_lcrc_relay_model.press(P_MIN - 1);
      step(3);
      chk(st, 4'h0);
      u_lcrc_relay_model.press(P_MAX + 1);
      step(3);
      chk(st, 4'h0);
      fork
         u_lcrc_relay_model.press(P_MIN);
         begin step(P_MIN); chk(st, 4'h0); end
      join
      step(2);
      chk(st, 4'h3);
      cut(2'h0);
      step(3);
      u_lcrc_relay_model.press(P_MAX);
      step(3);
      chk(st, 4'h3);
   endtask
   task automatic t_auto;
      int n;
      auto_reset_i = 1'b1;
      for (int s = 0; s < 4; s++) begin
         cut(s[1:0]);
         n = 0;
         while (out_a !== 1'b1 && n < 300) begin step(1); n++; end
         if (s == 3) chk({3'h0, n >= R_BOTH && n <= R_BOTH + 3}, 4'h1);
         else chk({3'h0, n >= R_ONE && n <= R_ONE + 3}, 4'h1);
      end
      auto_reset_i = 1'b0;
   endtask
   task automatic t_lock;
      fault_i = 1'b1;
      step(3);
      chk(st, 4'h4);
      fault_i = 1'b0;
      u_lcrc_relay_model.press(P_MIN);
      step(3);
      chk(st, 4'h4);
      u_lcrc_relay_model.press(L_MAX + 1);
      step(3);
      chk(st, 4'h4);
      u_lcrc_relay_model.press(L_MIN);
      step(3);
      chk(st, 4'h3);
   endtask
   task automatic t_five;
      five_pin_i = 1'b1;
      cut(2'h0);
      u_lcrc_relay_model.press(P_MIN);
      step(3);
      chk(st, 4'h0);
      fb_stuck = 1'b1;
      auto_reset_i = 1'b1;
      cut(2'h0);
      step(R_ONE + 6);
      chk(st, 4'h3);
      {five_pin_i, fb_stuck, auto_reset_i} = 3'h0;
   endtask
   task automatic t_mute;
      mute_four_i = 1'b1;
      muting_sensor_i = 4'h4;
      step(3);
      chk(active, 4'h4);
      chk({3'h0, lamp}, 4'h1);
      mute_four_i = 1'b0;
      step(3);
      chk({lamp, active[2:0]}, 4'h0);
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      step(4);
      srst_i = 1'b0;
      step(1);
      chk(st, 4'h0);
      t_manual();
      t_auto();
      t_lock();
      t_five();
      t_mute();
      summarize();
   end
endmodule
`default_nettype wire
